// file: rtl/uart_baud_irq_wake.v
// Serial port with baud generator, interrupt enables, data buffer and RX wake
`timescale 1ns/1ps
`include "uart_baud_irq_wake_map.vh"
module uart_baud_irq_wake (
  input  wire       clk_in,          // Block clock
  input  wire       sys_rst_in,      // Synchronous reset, active high
  input  wire       uart_clk_on_in,  // High while the UART clock runs
  input  wire [2:0] addr_in,         // Register index
  input  wire [7:0] wdata_in,        // Write data
  input  wire       wr_in,           // Write strobe
  input  wire       rd_in,           // Read strobe
  input  wire       rx_in,           // Serial receive pin
  output reg  [7:0] rdata_out,       // Read data, cycle after strobe
  output reg        tx_out,          // Serial transmit pin
  output reg        tx_oe_out,       // High while driving TX
  output reg        irq_out,         // UART interrupt request
  output reg        wake_req_out     // RX-edge wake request
);

  // One-hot states of the transmitter
  localparam [4:0] TX_IDLE  = 5'h01;
  localparam [4:0] TX_START = 5'h02;
  localparam [4:0] TX_DATA  = 5'h04;
  localparam [4:0] TX_PAR   = 5'h08;
  localparam [4:0] TX_STOP  = 5'h10;
  // One-hot states of the receiver
  localparam [3:0] RX_IDLE  = 4'h1;
  localparam [3:0] RX_START = 4'h2;
  localparam [3:0] RX_DATA  = 4'h4;
  localparam [3:0] RX_STOP  = 4'h8;

  reg  [7:0] ctrl_one;        // Format and enable
  reg  [7:0] ctrl_two;        // Enables, speed, wake
  reg  [7:0] tx_hold;         // Write side of data buffer
  reg  [7:0] rx_hold;         // Read side of data buffer
  reg        rx_bit8;         // Ninth received bit
  reg  [7:0] baud_div;        // Divisor N
  reg  [7:0] baud_cnt;        // Baud timer
  reg  [1:0] pre_cnt;         // Low-speed divide by four
  reg        tick;            // Sixteen ticks per bit
  reg        tx_empty_flag;   // Buffer can take data
  reg        tx_idle_flag;    // No frame in progress
  reg        rx_available_flag; // Received byte waiting
  reg        overrun_flag;    // Byte lost
  reg        frame_err;       // Bad stop bit
  reg        tx_pending;      // Buffer holds unsent data
  reg  [4:0] tx_state;        // Transmit state
  reg  [8:0] tx_shift;        // Transmit shift register
  reg  [3:0] tx_cnt;          // Bits left
  reg  [3:0] tx_sub;          // Ticks within bit
  reg        tx_par;          // Running parity
  reg        tx_stop2;        // Second stop pending
  reg  [3:0] rx_state;        // Receive state
  reg  [8:0] rx_shift;        // Receive shift register
  reg  [3:0] rx_cnt;          // Bits left
  reg  [3:0] rx_sub;          // Ticks within bit
  reg  [2:0] rx_sync;         // Three-stage RX synchroniser
  reg        wake_flag;       // Sticky wake request
  reg  [2:0] clk_sync;        // Clock-running synchroniser
  reg        clk_on;          // Agreed UART clock level
  reg        rx_prev;         // Last agreed RX level
  wire       rx_s;            // RX level at the last synchroniser stage
  wire       rx_fall;         // Agreed falling edge
  wire       uart_on;         // UART globally enabled
  wire       tx_on;           // Transmitter enabled
  wire       rx_on;           // Receiver enabled
  wire       nine;            // Nine-bit frames
  wire [3:0] nbits;           // Frame data bit count
  wire       wr_data;         // Data buffer write
  wire       rd_data;         // Data buffer read

  // Bits per frame, shared by both directions
  function [3:0] frame_bits;
    input is_nine;
    begin
      frame_bits = is_nine ? 4'h9 : 4'h8;
    end
  endfunction

  assign rx_s    = rx_sync[2];
  assign rx_fall = (rx_sync[2] == rx_sync[1]) & ~rx_sync[1] & rx_prev;
  assign uart_on = ctrl_one[`C1_ENABLE];
  assign tx_on   = uart_on & ctrl_two[`C2_TX_EN];
  assign rx_on   = uart_on & ctrl_two[`C2_RX_EN];
  assign nine    = ctrl_one[`C1_NINE_BIT];
  assign nbits   = frame_bits(nine);
  assign wr_data = wr_in & (addr_in == `OFS_DATA_BUF);
  assign rd_data = rd_in & (addr_in == `OFS_DATA_BUF);

  // Synchronisers and agreed RX and clock levels
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      rx_sync  <= 3'h7;
      clk_sync <= 3'h0;
      rx_prev  <= 1'b1;
      clk_on   <= 1'b0;
    end
    else
    begin
      rx_sync  <= {rx_sync[1:0], rx_in};
      clk_sync <= {clk_sync[1:0], uart_clk_on_in};
      // Hold the last level the two later stages agreed on
      if (rx_sync[2] == rx_sync[1])
        rx_prev <= rx_sync[2];
      // Clock level counts once the later stages agree
      if (clk_sync[2] == clk_sync[1])
        clk_on <= clk_sync[2];
    end
  end

  // Baud timer with speed select
  always @(posedge clk_in)
  begin
    if (sys_rst_in | ~uart_on)
    begin
      baud_cnt <= 8'h00;
      pre_cnt  <= 2'h0;
      tick     <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (ctrl_two[`C2_HIGH_SPEED] | (pre_cnt == `DIV_LOW_SPEED))
      begin
        pre_cnt <= 2'h0;
        if (baud_cnt == 8'h00)
        begin
          baud_cnt <= baud_div;
          tick     <= 1'b1;
        end
        else
          baud_cnt <= baud_cnt - 8'h01;
      end
      else
        pre_cnt <= pre_cnt + 2'h1;
    end
  end

  // Register writes, flags and transmitter
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_one      <= `RST_CTRL_ONE;
      ctrl_two      <= `RST_CTRL_TWO;
      baud_div      <= `RST_BAUD_DIV;
      tx_hold       <= 8'h00;
      tx_pending    <= 1'b0;
      tx_empty_flag <= 1'b1;
      tx_idle_flag  <= 1'b1;
      tx_state      <= TX_IDLE;
      tx_shift      <= 9'h1FF;
      tx_cnt        <= 4'h0;
      tx_sub        <= 4'h0;
      tx_par        <= 1'b0;
      tx_stop2      <= 1'b0;
      tx_out        <= 1'b1;
      tx_oe_out     <= 1'b0;
    end
    else
    begin
      tx_oe_out <= tx_on;
      // Control and divisor writes
      if (wr_in & (addr_in == `OFS_CTRL_ONE))
        ctrl_one <= wdata_in;
      else if (wr_in & (addr_in == `OFS_CTRL_TWO))
        ctrl_two <= wdata_in;
      else if (wr_in & (addr_in == `OFS_BAUD_DIV))
        baud_div <= wdata_in;
      if (wr_data & tx_empty_flag)
      begin
        tx_hold       <= wdata_in;
        tx_pending    <= 1'b1;
        tx_empty_flag <= 1'b0;
        tx_idle_flag  <= 1'b0;
      end
      if (~tx_on)
      begin
        // Disabled transmitter drops everything
        tx_state      <= TX_IDLE;
        tx_pending    <= 1'b0;
        tx_empty_flag <= 1'b1;
        tx_idle_flag  <= 1'b1;
        tx_out        <= 1'b1;
      end
      else if (tick)
      begin
        tx_sub <= tx_sub + 4'h1;
        case (tx_state)
          TX_IDLE:
          begin
            tx_sub <= 4'h0;
            if (tx_pending)
            begin
              tx_pending    <= 1'b0;
              tx_empty_flag <= 1'b1;
              tx_shift      <= {ctrl_one[`C1_TX_BIT8], tx_hold};
              tx_par        <= ctrl_one[`C1_PAR_ODD];
              tx_out        <= 1'b0;
              tx_state      <= TX_START;
            end
          end
          TX_START:
            if (tx_sub == `TICKS_PER_BIT)
            begin
              tx_cnt   <= ctrl_one[`C1_PAR_EN] ? nbits - 4'h1 : nbits;
              tx_out   <= tx_shift[0];
              tx_par   <= tx_par ^ tx_shift[0];
              tx_shift <= {1'b1, tx_shift[8:1]};
              tx_state <= TX_DATA;
            end
          TX_DATA:
            if (tx_sub == `TICKS_PER_BIT)
            begin
              if (tx_cnt == 4'h1)
              begin
                if (ctrl_one[`C1_PAR_EN])
                begin
                  tx_out   <= tx_par;
                  tx_state <= TX_PAR;
                end
                else
                begin
                  tx_out   <= 1'b1;
                  tx_stop2 <= ctrl_one[`C1_TWO_STOP];
                  tx_state <= TX_STOP;
                end
              end
              else
              begin
                tx_out   <= tx_shift[0];
                tx_par   <= tx_par ^ tx_shift[0];
                tx_shift <= {1'b1, tx_shift[8:1]};
              end
              tx_cnt <= tx_cnt - 4'h1;
            end
          TX_PAR:
            if (tx_sub == `TICKS_PER_BIT)
            begin
              tx_out   <= 1'b1;
              tx_stop2 <= ctrl_one[`C1_TWO_STOP];
              tx_state <= TX_STOP;
            end
          TX_STOP:
            if (tx_sub == `TICKS_PER_BIT)
            begin
              if (tx_stop2)
                tx_stop2 <= 1'b0;
              else
              begin
                tx_state <= TX_IDLE;
                if (~tx_pending)
                  tx_idle_flag <= 1'b1;
              end
            end
          default:
            tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // Receiver and its flags
  always @(posedge clk_in)
  begin
    if (sys_rst_in | ~rx_on)
    begin
      rx_state          <= RX_IDLE;
      rx_shift          <= 9'h000;
      rx_hold           <= 8'h00;
      rx_bit8           <= 1'b0;
      rx_cnt            <= 4'h0;
      rx_sub            <= 4'h0;
      rx_available_flag <= 1'b0;
      overrun_flag      <= 1'b0;
      frame_err         <= 1'b0;
    end
    else
    begin
      if (rd_data)
      begin
        rx_available_flag <= 1'b0;
        overrun_flag      <= 1'b0;
      end
      if (rx_state == RX_IDLE)
      begin
        rx_sub <= 4'h0;
        if (rx_fall)
          rx_state <= RX_START;
      end
      else if (tick)
      begin
        rx_sub <= rx_sub + 4'h1;
        case (rx_state)
          RX_START:
            if (rx_sub == `TICKS_HALF_BIT)
            begin
              rx_sub   <= 4'h0;
              rx_cnt   <= nbits;
              rx_state <= rx_s ? RX_IDLE : RX_DATA;
            end
          RX_DATA:
            if (rx_sub == `TICKS_PER_BIT)
            begin
              rx_shift <= {rx_s, rx_shift[8:1]};
              rx_cnt   <= rx_cnt - 4'h1;
              if (rx_cnt == 4'h1)
                rx_state <= RX_STOP;
            end
          RX_STOP:
            if (rx_sub == `TICKS_PER_BIT)
            begin
              rx_state  <= RX_IDLE;
              frame_err <= ~rx_s;
              if (rx_available_flag & ~rd_data)
                overrun_flag <= 1'b1;
              else
              begin
                rx_hold           <= nine ? rx_shift[7:0] : rx_shift[8:1];
                rx_bit8           <= rx_shift[8];
                rx_available_flag <= 1'b1;
              end
            end
          default:
            rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Wake request, interrupt and read data
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      wake_flag    <= 1'b0;
      wake_req_out <= 1'b0;
      irq_out      <= 1'b0;
      rdata_out    <= 8'h00;
    end
    else
    begin
      if (clk_on)
        wake_flag <= 1'b0;
      else if (ctrl_two[`C2_WAKE_EN] & rx_fall)
        wake_flag <= 1'b1;
      wake_req_out <= wake_flag;
      irq_out <= (ctrl_two[`C2_RX_IE] & (overrun_flag | rx_available_flag))
               | (ctrl_two[`C2_TX_IDLE_IE] & tx_idle_flag)
               | (ctrl_two[`C2_TX_EMPTY_IE] & tx_empty_flag)
               | (ctrl_two[`C2_RX_IE] & wake_flag);
      // Read decode
      rdata_out <= 8'h00;
      if (rd_in & (addr_in == `OFS_CTRL_ONE))
        rdata_out <= {ctrl_one[7:2], rx_bit8, 1'b0};
      else if (rd_in & (addr_in == `OFS_CTRL_TWO))
        rdata_out <= ctrl_two;
      else if (rd_in & (addr_in == `OFS_STATUS))
        rdata_out <= {1'b0, wake_flag, rx_state == RX_IDLE, overrun_flag, frame_err,
                      rx_available_flag, tx_idle_flag, tx_empty_flag};
      else if (rd_data)
        rdata_out <= rx_hold;
      else if (rd_in & (addr_in == `OFS_BAUD_DIV))
        rdata_out <= baud_div;
    end
  end

endmodule

// file: rtl/uart_baud_irq_wake_map.vh
// Register offsets, field positions and reset values of the serial port
`ifndef UART_BAUD_IRQ_WAKE_MAP_VH
`define UART_BAUD_IRQ_WAKE_MAP_VH
// Register offsets (word index on the plain port)
`define OFS_CTRL_ONE     3'h0
`define OFS_CTRL_TWO     3'h1
`define OFS_STATUS       3'h2
`define OFS_DATA_BUF     3'h3
`define OFS_BAUD_DIV     3'h4
// Control one field positions
`define C1_ENABLE        7
`define C1_NINE_BIT      6
`define C1_PAR_EN        5
`define C1_PAR_ODD       4
`define C1_TWO_STOP      3
`define C1_TX_BIT8       0
// Control two field positions
`define C2_TX_EN         7
`define C2_RX_EN         6
`define C2_HIGH_SPEED    5
`define C2_WAKE_EN       3
`define C2_RX_IE         2
`define C2_TX_IDLE_IE    1
`define C2_TX_EMPTY_IE   0
// Status field positions
`define ST_WAKE          6
`define ST_RX_IDLE       5
`define ST_OVERRUN       4
`define ST_FRAME_ERR     3
`define ST_RX_AVAIL      2
`define ST_TX_IDLE       1
`define ST_TX_EMPTY      0
// Reset values
`define RST_CTRL_ONE     8'h00
`define RST_CTRL_TWO     8'h00
`define RST_BAUD_DIV     8'h00
// Sub-bit sampling counts per bit and low-speed prescale count
`define TICKS_PER_BIT    4'hF
`define TICKS_HALF_BIT   4'h7
`define DIV_LOW_SPEED    2'h3
`endif

// file: verif/uart_baud_irq_wake_sva.sv
// Checker for interrupt, wake, read and frame behaviour at the block ports
`timescale 1ns/1ps
`include "uart_baud_irq_wake_map.vh"
module uart_baud_irq_wake_sva (
  input wire       clk_in,
  input wire       sys_rst_in,
  input wire       uart_clk_on_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire       rx_in,
  input wire [7:0] rdata_out,
  input wire       tx_out,
  input wire       tx_oe_out,
  input wire       irq_out,
  input wire       wake_req_out
);
  reg [7:0] c2;      // Shadow of control two
  reg [3:0] off_run; // Cycles with UART clock stopped, saturating
  // Shadow control two, count stopped-clock cycles
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      c2      <= `RST_CTRL_TWO;
      off_run <= 4'h0;
    end
    else
    begin
      if (wr_in && addr_in == `OFS_CTRL_TWO)
        c2 <= wdata_in;
      off_run <= uart_clk_on_in ? 4'h0 : off_run + {3'h0, off_run != 4'hF};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Status read followed by its answer cycle
  sequence s_stat_rd;
    rd_in && addr_in == `OFS_STATUS ##1 1'b1;
  endsequence
  AST_RD_ZERO: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside answer cycle");
  AST_WAKE_RISE: assert property (
    off_run == 4'hF && c2[`C2_WAKE_EN] && $fell(rx_in) |-> ##[1:8] wake_req_out)
    else $error("no wake after RX fall");
  AST_NO_WAKE_ON: assert property (uart_clk_on_in [*8] |-> !wake_req_out)
    else $error("wake while UART clock runs");
  AST_NO_WAKE_DIS: assert property ($rose(wake_req_out) |-> c2[`C2_WAKE_EN])
    else $error("wake with wake enable clear");
  AST_IRQ_OFF: assert property ((c2[2:0] == 3'h0) [*2] |-> !irq_out)
    else $error("irq with all enables clear");
  AST_IRQ_RX: assert property (s_stat_rd ##0 c2[`C2_RX_IE] &&
    (rdata_out[`ST_RX_AVAIL] || rdata_out[`ST_OVERRUN]) |-> ##[0:2] irq_out)
    else $error("receive flag without irq");
  AST_IRQ_IDLE: assert property (s_stat_rd ##0 c2[`C2_TX_IDLE_IE] &&
    rdata_out[`ST_TX_IDLE] |-> ##[0:2] irq_out)
    else $error("idle flag without irq");
  AST_IRQ_EMPTY: assert property (s_stat_rd ##0 c2[`C2_TX_EMPTY_IE] &&
    rdata_out[`ST_TX_EMPTY] |-> ##[0:2] irq_out)
    else $error("empty flag without irq");
  AST_START_BIT: assert property ($fell(tx_out) |=> (!tx_out) [*8])
    else $error("start bit too short");
endmodule

bind uart_baud_irq_wake uart_baud_irq_wake_sva chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .uart_clk_on_in(uart_clk_on_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rx_in(rx_in), .rdata_out(rdata_out), .tx_out(tx_out),
  .tx_oe_out(tx_oe_out), .irq_out(irq_out), .wake_req_out(wake_req_out));

// file: verif/uart_remote_model.sv
// Remote serial device: frame receiver and sender
`timescale 1ns/1ps
module uart_remote_model (
  input  wire        clk_in,      // Bench clock
  input  wire        line_in,     // From block transmitter
  input  wire [15:0] bit_clks_in, // Clocks per bit
  output logic       line_out,    // To block receiver
  output logic [7:0] got_out,     // Last captured data bits
  output logic       stop_out,    // Level in stop slot
  output logic [7:0] frames_out   // Captured frame count
);
  integer i;
  initial
  begin
    line_out   = 1'b1;
    frames_out = 8'h00;
  end
  always
  begin
    @(negedge line_in);
    repeat (bit_clks_in / 2) @(posedge clk_in);
    if (line_in === 1'b0)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        repeat (bit_clks_in) @(posedge clk_in);
        got_out[i] = line_in;
      end
      repeat (bit_clks_in) @(posedge clk_in);
      stop_out   = line_in;
      frames_out = frames_out + 8'h01;
    end
  end
  task send_frame(input [7:0] d);
    integer k;
    begin
      for (k = 0; k < 10; k = k + 1)
      begin
        @(posedge clk_in);
        line_out <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : d[k - 1];
        repeat (bit_clks_in - 1) @(posedge clk_in);
      end
    end
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
`include "uart_baud_irq_wake_map.vh"
module testbench;
  reg         clk_in, sys_rst_in, uart_clk_on_in, wr_in, rd_in;
  reg  [2:0]  addr_in;
  reg  [7:0]  wdata_in, d;
  reg  [15:0] bit_clks;  // Expected clocks per bit
  wire [7:0]  rdata_out, got, frames;
  wire        tx_out, tx_oe_out, irq_out, wake_req_out, rx_line, stop_b;
  wire        tx_line = tx_oe_out ? tx_out : 1'b1; // Pull-up when released
  integer     err_count, n_tests, i;
  uart_baud_irq_wake uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .uart_clk_on_in(uart_clk_on_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rx_in(rx_line), .rdata_out(rdata_out), .tx_out(tx_out),
    .tx_oe_out(tx_oe_out), .irq_out(irq_out), .wake_req_out(wake_req_out));
  uart_remote_model partner (.clk_in(clk_in), .line_in(tx_line), .bit_clks_in(bit_clks),
    .line_out(rx_line), .got_out(got), .stop_out(stop_b), .frames_out(frames));
  // Clock, 100 ns period
  always #50 clk_in = ~clk_in;
  // Compare and count
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  // One-cycle write strobe
  task wr(input [2:0] a, input [7:0] v);
    begin
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
    end
  endtask
  // One-cycle read strobe, data in next cycle
  task rd(input [2:0] a, output [7:0] v);
    begin
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
    end
  endtask
  // Poll a status bit, bounded
  task wait_bit(input integer b, input v);
    integer k;
    reg [7:0] s;
    begin
      s = ~{8{v}};
      for (k = 0; k < 3000 && s[b] !== v; k = k + 1)
        rd(`OFS_STATUS, s);
      check({7'h0, s[b]}, {7'h0, v});
    end
  endtask
  // Send a byte and compare what the far side saw
  task tx_byte(input [7:0] v, input [7:0] exp);
    integer k;
    reg [7:0] f0;
    begin
      wait_bit(`ST_TX_EMPTY, 1'b1);
      f0 = frames;
      wr(`OFS_DATA_BUF, v);
      for (k = 0; k < 3000 && frames == f0; k = k + 1)
        @(posedge clk_in);
      check(frames - f0, 8'h01);
      check(got, exp);
      check({7'h0, stop_b}, 8'h01);
    end
  endtask
  // Counts and verdict
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Watchdog, about 40000 clocks
  initial
  begin
    #4000000;
    err_count = err_count + 1;
    finish_test;
  end
  // Main sequence
  initial
  begin
    clk_in = 0; sys_rst_in = 1; uart_clk_on_in = 1; wr_in = 0; rd_in = 0;
    addr_in = 3'h0; wdata_in = 8'h00; bit_clks = 16'h0080; err_count = 0; n_tests = 0;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    check({6'h0, tx_oe_out, tx_out}, 8'h01);
    rd(`OFS_CTRL_ONE, d); check(d, `RST_CTRL_ONE);
    rd(`OFS_CTRL_TWO, d); check(d, `RST_CTRL_TWO);
    rd(`OFS_BAUD_DIV, d); check(d, `RST_BAUD_DIV);
    rd(3'h5, d); check(d, 8'h00);
    wr(`OFS_BAUD_DIV, 8'hFF); rd(`OFS_BAUD_DIV, d); check(d, 8'hFF);
    // Low speed, N=1: 64*2 clocks per bit
    wr(`OFS_BAUD_DIV, 8'h01); wr(`OFS_CTRL_ONE, 8'h80); wr(`OFS_CTRL_TWO, 8'hC0);
    tx_byte(8'hA5, 8'hA5);
    // High speed, N=3: 16*4 clocks per bit
    bit_clks = 16'h0040;
    wr(`OFS_BAUD_DIV, 8'h03); wr(`OFS_CTRL_TWO, 8'hE0);
    tx_byte(8'h3C, 8'h3C);
    // Parity in MSB: three ones in low seven bits; then two stop bits without parity
    wr(`OFS_CTRL_ONE, 8'hB0); tx_byte(8'h13, 8'h13);
    wr(`OFS_CTRL_ONE, 8'hA0); tx_byte(8'h13, 8'h93);
    wr(`OFS_CTRL_ONE, 8'h88); tx_byte(8'hF0, 8'hF0);
    // Nine data bits, ninth low, lands in the far side's stop slot
    wr(`OFS_CTRL_ONE, 8'hC0);
    d = frames;
    wr(`OFS_DATA_BUF, 8'h81);
    for (i = 0; i < 3000 && frames == d; i = i + 1)
      @(posedge clk_in);
    check(got, 8'h81);
    check({7'h0, stop_b}, 8'h00);
    // Receive at the shared baud and format
    wr(`OFS_CTRL_ONE, 8'h80);
    partner.send_frame(8'h5A);
    wait_bit(`ST_RX_AVAIL, 1'b1);
    rd(`OFS_DATA_BUF, d); check(d, 8'h5A);
    // Each enable alone, idle and empty set, nothing received; then receive enable with a byte waiting, cleared by a data read
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`OFS_CTRL_TWO, 8'hE0 | (8'h01 << i));
      rd(`OFS_STATUS, d);
      check(d & 8'h03, 8'h03);
      repeat (3) @(posedge clk_in);
      check({7'h0, irq_out}, {7'h0, i < 2});
    end
    wr(`OFS_CTRL_TWO, 8'hE4);
    partner.send_frame(8'h66);
    wait_bit(`ST_RX_AVAIL, 1'b1);
    check({7'h0, irq_out}, 8'h01);
    rd(`OFS_DATA_BUF, d); check(d, 8'h66);
    repeat (3) @(posedge clk_in);
    check({7'h0, irq_out}, 8'h00);
    // Wake with clock stopped
    wr(`OFS_CTRL_TWO, 8'h0C);
    uart_clk_on_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    fork
      partner.send_frame(8'h00);
    join_none
    for (i = 0; i < 200 && wake_req_out !== 1'b1; i = i + 1)
      @(posedge clk_in);
    check({7'h0, wake_req_out}, 8'h01);
    repeat (2) @(posedge clk_in);
    check({7'h0, irq_out}, 8'h01);
    repeat (700) @(posedge clk_in);
    uart_clk_on_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    check({7'h0, wake_req_out}, 8'h00);
    partner.send_frame(8'h00);
    check({7'h0, wake_req_out}, 8'h00);
    // Wake enable clear, clock stopped
    wr(`OFS_CTRL_TWO, 8'h04);
    uart_clk_on_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    partner.send_frame(8'h00);
    check({7'h0, wake_req_out}, 8'h00);
    uart_clk_on_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    finish_test;
  end
endmodule
